// >>> rtl/motor_prot_pkg.sv
package motor_prot_pkg;

  // register addresses (chosen map)
  localparam logic [1:0] ADDR_TRIG_CTRL  = 2'h0;
  localparam logic [1:0] ADDR_MODE_SEL   = 2'h1;
  localparam logic [1:0] ADDR_GATE_LEVEL = 2'h2;
  localparam logic [1:0] ADDR_STATUS     = 2'h3;

  // protection_trigger_control fields
  localparam int SW_VALUE_BIT    = 7;
  localparam int SW_ENABLE_BIT   = 6;
  localparam int OVF_TRIG_BIT    = 5;
  localparam int CMP_TRIG_BIT    = 4;
  localparam int OC_TRIG_BIT     = 3;
  localparam int LIM_TRIG_BIT    = 2;
  localparam int OC_SW_BIT       = 1;
  localparam int OC_HW_BIT       = 0;

  // protection_mode_select fields
  localparam int SW_REL_BIT      = 4;
  localparam int LIM_RESTART_BIT = 3;
  localparam int OC_REL_BIT      = 2;
  localparam int CMP_REL_BIT     = 1;
  localparam int OVF_REL_BIT     = 0;

  localparam logic [7:0] TRIG_CTRL_RESET  = 8'h00;
  localparam logic [4:0] MODE_SEL_RESET   = 5'h00;
  localparam logic [5:0] GATE_LEVEL_RESET = 6'h00;
  localparam logic [7:0] MODE_SEL_MASK    = 8'h1f;
  localparam logic [7:0] GATE_LEVEL_MASK  = 8'h3f;

  // status register fields
  localparam int ST_PROTECT_BIT = 0;
  localparam int ST_OC_BIT      = 1;
  localparam int ST_HOLD_BIT    = 2;

  // gate output order: a_top, a_bottom, b_top, b_bottom, c_top, c_bottom
  localparam logic [5:0] BRAKE_PATTERN = 6'h2a;
  localparam logic [5:0] FREE_PATTERN  = 6'h00;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_FELL  = 2'b01,
    SEQ_ARMED = 2'b10
  } seq_state_t;

endpackage

// >>> rtl/release_seq.sv
`timescale 1ns/100ps
// detects a high, low, high sequence of one enable bit across register writes
module release_seq
  import motor_prot_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic write_i,
  input  wire logic old_bit_i,
  input  wire logic new_bit_i,
  output logic      release_o
);

  seq_state_t state;
  seq_state_t next_state;

  always_comb begin
    next_state = state;
    if (write_i) begin
      unique case (state)
        SEQ_IDLE:  next_state = (old_bit_i && !new_bit_i) ? SEQ_FELL : SEQ_IDLE;
        SEQ_FELL:  next_state = new_bit_i ? SEQ_IDLE : SEQ_FELL;
        default:   next_state = SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= SEQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // one-cycle pulse in the cycle after the rising write that completes the sequence
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      release_o <= 1'b0;
    end else begin
      release_o <= write_i && (state == SEQ_FELL) && new_bit_i;
    end
  end

endmodule

// >>> rtl/restart_sync.sv
`timescale 1ns/100ps
// holds off a drive restart until the next pwm period start when asked to
module restart_sync (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic event_i,
  input  wire logic wait_period_i,
  input  wire logic period_start_i,
  output logic      block_o
);

  logic waiting;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      waiting <= 1'b0;
    end else if (event_i && wait_period_i) begin
      waiting <= 1'b1;
    end else if (period_start_i) begin
      waiting <= 1'b0;
    end
  end

  assign block_o = event_i || waiting;

endmodule

// >>> rtl/motor_protection_control.sv
`timescale 1ns/100ps
module motor_protection_control
  import motor_prot_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       capture_overflow_event_i,
  input  wire logic       capture_compare_event_i,
  input  wire logic       overcurrent_pulse_i,
  input  wire logic       current_limit_event_i,
  input  wire logic       pwm_period_start_i,
  input  wire logic       brake_select_i,
  input  wire logic [5:0] drive_i,
  output logic      [5:0] gate_o,
  output logic            protect_o,
  output logic            oc_shutdown_active_o
);

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] trig_ctrl;
  logic [4:0] mode_sel;
  logic [5:0] gate_levels;
  logic       trig_wr;
  logic       sw_release;
  logic       oc_hw_release;
  logic       sw_latched;
  logic       oc_latched;
  logic       oc_pause_latched;
  logic       cap_latched;
  logic       limit_block;
  logic       protect;
  logic       oc_shutdown;

  assign trig_wr = wr_i && (addr_i == ADDR_TRIG_CTRL);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_ctrl <= TRIG_CTRL_RESET;
    end else if (trig_wr) begin
      trig_ctrl <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_sel <= MODE_SEL_RESET;
    end else if (wr_i && (addr_i == ADDR_MODE_SEL)) begin
      mode_sel <= wdata_i[4:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_levels <= GATE_LEVEL_RESET;
    end else if (wr_i && (addr_i == ADDR_GATE_LEVEL)) begin
      gate_levels <= wdata_i[5:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // release sequence detectors

  release_seq u_sw_seq (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .write_i   (trig_wr),
    .old_bit_i (trig_ctrl[SW_ENABLE_BIT]),
    .new_bit_i (wdata_i[SW_ENABLE_BIT]),
    .release_o (sw_release)
  );

  release_seq u_oc_seq (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .write_i   (trig_wr),
    .old_bit_i (trig_ctrl[OC_HW_BIT]),
    .new_bit_i (wdata_i[OC_HW_BIT]),
    .release_o (oc_hw_release)
  );

  //////////////////////////////////////////////////////////////////////////////
  // protection sources

  // software mode: value bit drives protection; pause keeps it until release
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_latched <= 1'b0;
    end else if (trig_ctrl[SW_ENABLE_BIT] && trig_ctrl[SW_VALUE_BIT]
                 && mode_sel[SW_REL_BIT]) begin
      sw_latched <= 1'b1;
    end else if (sw_release) begin
      sw_latched <= 1'b0;
    end
  end

  // over-current pulse in pause mode holds protection until a software or over-current hardware release sequence
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_pause_latched <= 1'b0;
    end else if (overcurrent_pulse_i && trig_ctrl[OC_TRIG_BIT]
                 && mode_sel[OC_REL_BIT]) begin
      oc_pause_latched <= 1'b1;
    end else if (sw_release || oc_hw_release) begin
      oc_pause_latched <= 1'b0;
    end
  end

  // capture stall events act only in pause mode, when their mode_sel bit is set; otherwise they are ignored
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_latched <= 1'b0;
    end else if ((capture_overflow_event_i && trig_ctrl[OVF_TRIG_BIT]
                  && mode_sel[OVF_REL_BIT])
                 || (capture_compare_event_i && trig_ctrl[CMP_TRIG_BIT]
                  && mode_sel[CMP_REL_BIT])) begin
      cap_latched <= 1'b1;
    end else if (sw_release) begin
      cap_latched <= 1'b0;
    end
  end

  restart_sync u_limit (
    .ref_clk_i      (ref_clk_i),
    .rst_i          (rst_i),
    .event_i        (current_limit_event_i && trig_ctrl[LIM_TRIG_BIT]),
    .wait_period_i  (mode_sel[LIM_RESTART_BIT]),
    .period_start_i (pwm_period_start_i),
    .block_o        (limit_block)
  );

  always_comb begin
    protect = sw_latched || oc_pause_latched || cap_latched || limit_block
              || (trig_ctrl[SW_ENABLE_BIT] && trig_ctrl[SW_VALUE_BIT])
              || (overcurrent_pulse_i && trig_ctrl[OC_TRIG_BIT]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // over-current shutdown

  // set wins over release when both land in one cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_latched <= 1'b0;
    end else if (overcurrent_pulse_i && trig_ctrl[OC_TRIG_BIT]
                 && trig_ctrl[OC_HW_BIT]) begin
      oc_latched <= 1'b1;
    end else if (oc_hw_release) begin
      oc_latched <= 1'b0;
    end
  end

  always_comb begin
    oc_shutdown = oc_latched || trig_ctrl[OC_SW_BIT];
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_o <= FREE_PATTERN;
    end else if (oc_shutdown) begin
      gate_o <= gate_levels;
    end else if (protect) begin
      gate_o <= brake_select_i ? BRAKE_PATTERN : FREE_PATTERN;
    end else begin
      gate_o <= drive_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      protect_o            <= 1'b0;
      oc_shutdown_active_o <= 1'b0;
    end else begin
      protect_o            <= protect;
      oc_shutdown_active_o <= oc_shutdown;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        ADDR_TRIG_CTRL:  rdata_o <= trig_ctrl;
        ADDR_MODE_SEL:   rdata_o <= {3'h0, mode_sel} & MODE_SEL_MASK;
        ADDR_GATE_LEVEL: rdata_o <= {2'h0, gate_levels} & GATE_LEVEL_MASK;
        ADDR_STATUS: begin
          rdata_o                 <= 8'h00;
          rdata_o[ST_PROTECT_BIT] <= protect;
          rdata_o[ST_OC_BIT]      <= oc_shutdown;
          rdata_o[ST_HOLD_BIT]    <= sw_latched || oc_pause_latched || cap_latched;
        end
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule

// >>> verification/gate_pairs.sv
`timescale 1ns/100ps
// three half bridges on the six gate lines; flags a pair with both arms on
module gate_pairs (
  input  wire logic [5:0] gate_i,
  output logic            shorted_o
);
  assign shorted_o = |({gate_i[4], gate_i[2], gate_i[0]} & {gate_i[5], gate_i[3], gate_i[1]});
endmodule

// >>> verification/motor_prot_assertions.sv
`timescale 1ns/100ps
module motor_prot_assertions
  import motor_prot_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       brake_select_i,
  input wire logic [5:0] drive_i,
  input wire logic [5:0] gate_o,
  input wire logic       protect_o,
  input wire logic       oc_shutdown_active_o
);
  logic [7:0] tc;
  logic [5:0] lvl;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) tc <= 8'h00;
    else if (wr_i && addr_i == ADDR_TRIG_CTRL) tc <= wdata_i;
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) lvl <= 6'h00;
    else if (wr_i && addr_i == ADDR_GATE_LEVEL) lvl <= wdata_i[5:0];
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_trig; rd_i && addr_i == ADDR_TRIG_CTRL |=> rdata_o == $past(tc); endproperty
  a_rd_trig: assert property (p_rd_trig) else $error("trigger control readback");
  property p_rd_mode; rd_i && addr_i == ADDR_MODE_SEL |=> rdata_o[7:5] == 3'h0; endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("mode upper bits");
  property p_rd_lvl; rd_i && addr_i == ADDR_GATE_LEVEL |=> rdata_o == {2'b00, $past(lvl)}; endproperty
  a_rd_lvl: assert property (p_rd_lvl) else $error("level readback");
  property p_sw_force;
    wr_i && addr_i == ADDR_TRIG_CTRL && wdata_i[OC_SW_BIT] |-> ##2 oc_shutdown_active_o;
  endproperty
  a_sw_force: assert property (p_sw_force) else $error("shutdown not forced");
  property p_oc_cause;
    $rose(oc_shutdown_active_o) |-> $past(tc[OC_SW_BIT]) || $past(tc[OC_HW_BIT]);
  endproperty
  a_oc_cause: assert property (p_oc_cause) else $error("shutdown without enable");
  property p_oc_gate; oc_shutdown_active_o |-> gate_o == $past(lvl); endproperty
  a_oc_gate: assert property (p_oc_gate) else $error("shutdown levels wrong");
  property p_oc_hold;
    oc_shutdown_active_o && !wr_i && !$past(wr_i) && !$past(wr_i, 2) |=> oc_shutdown_active_o;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("shutdown dropped alone");
  property p_prot_gate;
    protect_o && !oc_shutdown_active_o
      |-> gate_o == ($past(brake_select_i) ? BRAKE_PATTERN : FREE_PATTERN);
  endproperty
  a_prot_gate: assert property (p_prot_gate) else $error("protect pattern wrong");
  property p_normal;
    !protect_o && !oc_shutdown_active_o && !rst_i && !$past(rst_i) && !$past(tc[LIM_TRIG_BIT])
      && !$past(tc[LIM_TRIG_BIT], 2) |-> gate_o == $past(drive_i);
  endproperty
  a_normal: assert property (p_normal) else $error("normal drive lost");
endmodule
bind motor_protection_control motor_prot_assertions u_motor_prot_assertions (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .brake_select_i(brake_select_i), .drive_i(drive_i),
  .gate_o(gate_o), .protect_o(protect_o), .oc_shutdown_active_o(oc_shutdown_active_o));

// >>> verification/testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  import motor_prot_pkg::*;
  logic       ref_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic       brk       = 1'b0;
  logic [4:0] ev        = 5'h00;
  logic [1:0] addr_i    = 2'h0;
  logic [7:0] wdata_i   = 8'h00;
  logic [5:0] drive     = 6'h15;
  logic [7:0] rdata_o, d;
  logic [5:0] gate_o, lvl;
  logic       protect_o, oc_o, shorted;
  int         failures = 0, comparisons = 0, seed;
  always #50 ref_clk_i = ~ref_clk_i;
  motor_protection_control u_motor_protection_control (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .capture_overflow_event_i(ev[3]), .capture_compare_event_i(ev[2]),
    .overcurrent_pulse_i(ev[1]), .current_limit_event_i(ev[0]), .pwm_period_start_i(ev[4]),
    .brake_select_i(brk), .drive_i(drive), .gate_o(gate_o), .protect_o(protect_o),
    .oc_shutdown_active_o(oc_o));
  gate_pairs u_gate_pairs (.gate_i(gate_o), .shorted_o(shorted));
  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK("rdata", e, rdata_o)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk_i);
    ev[i] <= 1'b1;
    @(posedge ref_clk_i);
    ev[i] <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    failures++;
    end_of_test();
  end
  initial begin
    seed = $urandom(57);
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      wr(2'h1, d);
      rd(2'h1, d & MODE_SEL_MASK);
      wr(2'h2, d);
      rd(2'h2, d & GATE_LEVEL_MASK);
      wr(2'h0, d & 8'hbc);
      rd(2'h0, d & 8'hbc);
    end
    // reset again in mid-run with every register holding random data
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h00);
    $display("register test done");
    lvl = 6'($urandom);
    drive <= 6'($urandom);
    wr(2'h2, {2'b00, lvl});
    wr(2'h0, 8'h02);
    cyc(2);
    `CHK("oc", 1'b1, oc_o)
    `CHK("gate", lvl, gate_o)
    rd(2'h3, 8'h02);
    wr(2'h0, 8'h00);
    cyc(2);
    `CHK("oc", 1'b0, oc_o)
    `CHK("gate", drive, gate_o)
    @(posedge ref_clk_i);
    drive <= 6'h15;
    wr(2'h0, 8'h08);
    wr(2'h0, 8'h09);
    pulse(1);
    cyc(9);
    `CHK("oc", 1'b1, oc_o)
    wr(2'h0, 8'h09);
    wr(2'h0, 8'h08);
    cyc(4);
    `CHK("oc", 1'b1, oc_o)
    wr(2'h0, 8'h09);
    cyc(4);
    `CHK("oc", 1'b0, oc_o)
    $display("shutdown test done");
    for (int m = 0; m < 2; m++) begin
      wr(2'h1, {5'h00, m[0], 2'b00});
      wr(2'h0, 8'h08);
      pulse(1);
      cyc(6);
      `CHK("prot", m[0], protect_o)
      wr(2'h0, 8'h48);
      wr(2'h0, 8'h08);
      wr(2'h0, 8'h48);
      cyc(4);
      `CHK("prot", 1'b0, protect_o)
      wr(2'h1, {3'h0, m[0], 4'h0});
      wr(2'h0, 8'hc0);
      cyc(3);
      `CHK("prot", 1'b1, protect_o)
      rd(2'h3, {5'h00, m[0], 2'b01});
      for (int b = 0; b < 2; b++) begin
        @(posedge ref_clk_i);
        brk <= b[0];
        cyc(3);
        `CHK("gate", b ? BRAKE_PATTERN : FREE_PATTERN, gate_o)
        `CHK("short", 1'b0, shorted)
      end
      wr(2'h0, 8'h40);
      cyc(3);
      `CHK("prot", m[0], protect_o)
      wr(2'h0, 8'h00);
      wr(2'h0, 8'h40);
      cyc(3);
      `CHK("prot", 1'b0, protect_o)
      wr(2'h0, 8'h00);
    end
    $display("protect test done");
    for (int m = 0; m < 2; m++) begin
      wr(2'h1, {4'h0, m[0], 3'h0});
      wr(2'h0, 8'h04);
      @(posedge ref_clk_i);
      ev[0] <= 1'b1;
      cyc(3);
      `CHK("blocked", 1'b1, gate_o !== drive)
      @(posedge ref_clk_i);
      ev[0] <= 1'b0;
      cyc(3);
      `CHK("restart", ~m[0], gate_o === drive)
      pulse(4);
      cyc(3);
      `CHK("gate", drive, gate_o)
    end
    wr(2'h0, 8'h00);
    $display("limit test done");
    wr(2'h1, 8'h03);
    for (int i = 2; i < 4; i++) begin
      d = 8'h04 << i;
      wr(2'h0, d);
      pulse(i);
      cyc(6);
      `CHK("prot", 1'b1, protect_o)
      wr(2'h0, d | 8'h40);
      wr(2'h0, d);
      wr(2'h0, d | 8'h40);
      cyc(4);
      `CHK("prot", 1'b0, protect_o)
    end
    wr(2'h0, 8'h00);
    pulse(2);
    pulse(3);
    cyc(3);
    `CHK("prot", 1'b0, protect_o)
    $display("capture test done");
    end_of_test();
  end
endmodule
